//--- pcs_map.svh
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// APB byte offsets of the register words
`define PCS_OFS_COUNTER_LOW 8'h00
`define PCS_OFS_HIGH_LATCH 8'h04
`define PCS_OFS_UPPER_LATCH 8'h08
`define PCS_OFS_STACK_PTR 8'h0c
`define PCS_OFS_TOP_LOW 8'h10
`define PCS_OFS_TOP_HIGH 8'h14
`define PCS_OFS_TOP_UPPER 8'h18
`define PCS_OFS_CONFIG 8'h1c
`define PCS_OFS_COUNTER_FULL 8'h20

// Stack pointer register fields
`define PCS_SP_PTR_LSB 0
`define PCS_SP_PTR_MSB 4
`define PCS_SP_UNF_BIT 6
`define PCS_SP_FULL_BIT 7

// Config register fields and reset values
`define PCS_CFG_OVR_EN_BIT 0
`define PCS_RST_OVR_EN 1'h1
`define PCS_RST_PC 21'h000000
`define PCS_RST_SP 5'h00

// Vectors, fetch step and sizes
`define PCS_VEC_RESET 21'h000000
`define PCS_VEC_INT_HIGH 21'h000008
`define PCS_VEC_INT_LOW 21'h000018
`define PCS_PC_STEP 21'h000002
`define PCS_SP_MAX 5'h1f
`define PCS_IMPL_LIMIT 21'h008000

`endif

//--- pcs_pkg.sv
package pcs_pkg;

	typedef enum logic [3:0] {
		PCS_OP_NONE = 4'h0,
		PCS_OP_ADVANCE = 4'h1,
		PCS_OP_JUMP = 4'h2,
		PCS_OP_CALL = 4'h3,
		PCS_OP_RELATIVE_CALL = 4'h4,
		PCS_OP_INT_ACK = 4'h5,
		PCS_OP_RETURN = 4'h6,
		PCS_OP_RETURN_WITH_LITERAL = 4'h7,
		PCS_OP_RETURN_FROM_INTERRUPT = 4'h8,
		PCS_OP_SW_PUSH = 4'h9,
		PCS_OP_SW_POP = 4'ha
	} pcs_op_type;

endpackage

//--- pcs_return_stack.sv
`timescale 1ns/10ps

module pcs_return_stack (
	input wire logic pclk,
	input wire logic pce,
	input wire logic wr_en,
	input wire logic [4:0] wr_index,
	input wire logic [20:0] wr_data,
	input wire logic [4:0] rd_index,
	output logic [20:0] rd_data
);

	// Index zero has no storage behind it
	logic [20:0] entry_mem [1:31];

	always_ff @(posedge pclk) begin
		if (pce && wr_en && (wr_index != 5'h00)) begin
			entry_mem[wr_index] <= wr_data;
		end
	end

	always_comb begin
		if (rd_index == 5'h00) begin
			rd_data = 21'h000000;
		end else begin
			rd_data = entry_mem[rd_index];
		end
	end

endmodule // pcs_return_stack

//--- pcs_program_counter.sv
`timescale 1ns/10ps
`include "pcs_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Program counter is 21 bits wide.
// - Fetch beyond implemented memory returns zeros.
// - Reset vector 0000h, interrupts 0008h, 0018h.
// - Low byte direct; upper bytes via latches, or read with the whole counter at 20h.
// - Low byte write loads latches into counter.
// - Low byte read copies counter into latches.
// - Bit 0 zero; fetch advances by two.
// - Calls, jumps, branches load target directly.
// - Calls, interrupts push; returns pop; latches untouched except by overflow reset.
// - Private stack, 31 entries, 5-bit pointer.
// - Push increments pointer, then writes entry.
// - Pop loads counter, then decrements pointer.
// - Reset clears pointer; index zero unbacked.
// - Top entry reachable as three byte registers.
// - Software reads and writes pointer, 0..31.
// - Thirty-first push sets full; software clears.
// - Overflow reset: store counter+2, reset, pointer zero.
// - No overflow reset: pointer sticks at 31.
// - Empty pop loads zero, sets underflow.
// - Software push increments and stores counter.
// - Software pop only decrements pointer.
module pcs_program_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcs_pkg::pcs_op_type core_op,
	input wire logic [20:0] core_target,
	input wire logic core_int_high,
	input wire logic [15:0] fetch_rdata,
	output logic [20:0] fetch_addr,
	output logic [15:0] fetch_opcode,
	output logic stack_full_flag,
	output logic stack_underflow_flag,
	output logic device_reset_out
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [20:0] pc_reg;
	logic [20:0] pc_next;
	logic [7:0] counter_high_latch_reg;
	logic [7:0] counter_high_latch_next;
	logic [4:0] counter_upper_latch_reg;
	logic [4:0] counter_upper_latch_next;
	logic [4:0] stack_pointer_reg;
	logic [4:0] stack_pointer_next;
	logic full_reg;
	logic full_next;
	logic underflow_reg;
	logic underflow_next;
	logic overflow_reset_enable_reg;
	logic overflow_reset_enable_next;
	logic dev_rst_reg;
	logic dev_rst_next;
	logic [15:0] opcode_reg;
	logic [15:0] opcode_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	logic ram_we;
	logic [4:0] ram_widx;
	logic [20:0] ram_wdata;
	logic [20:0] top_entry;

	logic apb_access;
	logic apb_done;
	logic apb_wr;
	logic apb_rd;
	logic addr_hit;
	logic [7:0] reg_ofs;
	logic [31:0] read_mux;

	logic push_req;
	logic [20:0] push_val;
	logic pop_req;
	logic pc_loaded_by_sw;

	////////////////////////////////////////////////////////////////////////////
	// Stack storage

	pcs_return_stack u_stack (
		.pclk(pclk),
		.pce(pce),
		.wr_en(ram_we),
		.wr_index(ram_widx),
		.wr_data(ram_wdata),
		.rd_index(stack_pointer_reg),
		.rd_data(top_entry)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// One wait state so that read data can come from a flip-flop
	assign apb_access = psel & penable & ~pready_reg;
	assign apb_done = psel & penable & pready_reg;
	assign apb_wr = apb_done & pwrite;
	assign apb_rd = apb_done & ~pwrite;
	assign reg_ofs = paddr[7:0];

	always_comb begin
		addr_hit = 1'b0;
		read_mux = 32'h00000000;
		if (paddr[31:8] == 24'h000000) begin
			addr_hit = 1'b1;
			unique case (reg_ofs)
				`PCS_OFS_COUNTER_LOW: read_mux = {24'h000000, pc_reg[7:0]};
				`PCS_OFS_HIGH_LATCH: read_mux = {24'h000000, counter_high_latch_reg};
				`PCS_OFS_UPPER_LATCH: read_mux = {27'h0000000, counter_upper_latch_reg};
				`PCS_OFS_STACK_PTR: begin
					read_mux[`PCS_SP_PTR_MSB:`PCS_SP_PTR_LSB] = stack_pointer_reg;
					read_mux[`PCS_SP_UNF_BIT] = underflow_reg;
					read_mux[`PCS_SP_FULL_BIT] = full_reg;
				end
				`PCS_OFS_TOP_LOW: read_mux = {24'h000000, top_entry[7:0]};
				`PCS_OFS_TOP_HIGH: read_mux = {24'h000000, top_entry[15:8]};
				`PCS_OFS_TOP_UPPER: read_mux = {27'h0000000, top_entry[20:16]};
				`PCS_OFS_CONFIG: read_mux[`PCS_CFG_OVR_EN_BIT] = overflow_reset_enable_reg;
				`PCS_OFS_COUNTER_FULL: read_mux = {11'h000, pc_reg};
				default: addr_hit = 1'b0;
			endcase
		end
	end

	always_comb begin
		pready_next = apb_access;
		pslverr_next = apb_access & ~addr_hit;
		prdata_next = prdata_reg;
		if (apb_access) begin
			prdata_next = pwrite ? 32'h00000000 : read_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter, latches and stack

	always_comb begin
		pc_next = pc_reg;
		counter_high_latch_next = counter_high_latch_reg;
		counter_upper_latch_next = counter_upper_latch_reg;
		stack_pointer_next = stack_pointer_reg;
		full_next = full_reg;
		underflow_next = underflow_reg;
		overflow_reset_enable_next = overflow_reset_enable_reg;
		dev_rst_next = 1'b0;
		ram_we = 1'b0;
		ram_widx = stack_pointer_reg;
		ram_wdata = top_entry;
		push_req = 1'b0;
		push_val = pc_reg;
		pop_req = 1'b0;
		pc_loaded_by_sw = 1'b0;

		// Software side first; the core operation below takes precedence, except that an advance yields to a low byte write
		if (apb_rd && addr_hit && (reg_ofs == `PCS_OFS_COUNTER_LOW)) begin
			counter_high_latch_next = pc_reg[15:8];
			counter_upper_latch_next = pc_reg[20:16];
		end
		if (apb_wr && addr_hit) begin
			unique case (reg_ofs)
				`PCS_OFS_COUNTER_LOW: begin
					pc_next = {counter_upper_latch_reg, counter_high_latch_reg,
						pwdata[7:1], 1'b0};
					pc_loaded_by_sw = 1'b1;
				end
				`PCS_OFS_HIGH_LATCH: counter_high_latch_next = pwdata[7:0];
				`PCS_OFS_UPPER_LATCH: counter_upper_latch_next = pwdata[4:0];
				`PCS_OFS_STACK_PTR: begin
					stack_pointer_next = pwdata[`PCS_SP_PTR_MSB:`PCS_SP_PTR_LSB];
					// Flags clear on a written zero, never set by software
					full_next = full_reg & pwdata[`PCS_SP_FULL_BIT];
					underflow_next = underflow_reg & pwdata[`PCS_SP_UNF_BIT];
				end
				`PCS_OFS_TOP_LOW: begin
					ram_we = 1'b1;
					ram_wdata = {top_entry[20:8], pwdata[7:0]};
				end
				`PCS_OFS_TOP_HIGH: begin
					ram_we = 1'b1;
					ram_wdata = {top_entry[20:16], pwdata[7:0], top_entry[7:0]};
				end
				`PCS_OFS_TOP_UPPER: begin
					ram_we = 1'b1;
					ram_wdata = {pwdata[4:0], top_entry[15:0]};
				end
				`PCS_OFS_CONFIG: overflow_reset_enable_next = pwdata[`PCS_CFG_OVR_EN_BIT];
				default: begin
				end
			endcase
		end

		// Core operations; only an overflow reset among them touches the latches
		unique case (core_op)
			pcs_pkg::PCS_OP_NONE: begin
			end
			pcs_pkg::PCS_OP_ADVANCE: begin
				if (!pc_loaded_by_sw) begin
					pc_next = pc_reg + `PCS_PC_STEP;
				end
			end
			pcs_pkg::PCS_OP_JUMP: pc_next = {core_target[20:1], 1'b0};
			pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_RELATIVE_CALL: begin
				push_req = 1'b1;
				pc_next = {core_target[20:1], 1'b0};
			end
			pcs_pkg::PCS_OP_INT_ACK: begin
				push_req = 1'b1;
				pc_next = core_int_high ? `PCS_VEC_INT_HIGH : `PCS_VEC_INT_LOW;
			end
			pcs_pkg::PCS_OP_RETURN, pcs_pkg::PCS_OP_RETURN_WITH_LITERAL,
			pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT: pop_req = 1'b1;
			pcs_pkg::PCS_OP_SW_PUSH: push_req = 1'b1;
			pcs_pkg::PCS_OP_SW_POP: begin
				if (stack_pointer_reg != `PCS_RST_SP) begin
					stack_pointer_next = stack_pointer_reg - 5'h01;
				end
			end
			default: begin
			end
		endcase

		if (pop_req) begin
			if (stack_pointer_reg == `PCS_RST_SP) begin
				pc_next = `PCS_VEC_RESET;
				underflow_next = 1'b1;
				stack_pointer_next = `PCS_RST_SP;
			end else begin
				pc_next = {top_entry[20:1], 1'b0};
				stack_pointer_next = stack_pointer_reg - 5'h01;
			end
		end

		if (push_req) begin
			ram_we = 1'b0;
			if (stack_pointer_reg == `PCS_SP_MAX) begin
				// Stack already full: the last entry is kept as it was
				full_next = 1'b1;
				if (overflow_reset_enable_reg) begin
					dev_rst_next = 1'b1;
					stack_pointer_next = `PCS_RST_SP;
					pc_next = `PCS_VEC_RESET;
				end else begin
					stack_pointer_next = `PCS_SP_MAX;
				end
			end else begin
				stack_pointer_next = stack_pointer_reg + 5'h01;
				ram_we = 1'b1;
				ram_widx = stack_pointer_reg + 5'h01;
				ram_wdata = push_val;
				if (stack_pointer_next == `PCS_SP_MAX) begin
					full_next = 1'b1;
					if (overflow_reset_enable_reg) begin
						ram_wdata = push_val + `PCS_PC_STEP;
						dev_rst_next = 1'b1;
						stack_pointer_next = `PCS_RST_SP;
						pc_next = `PCS_VEC_RESET;
					end
				end
			end
		end

		// Overflow reset also clears the latches as any device reset would
		if (dev_rst_next) begin
			counter_high_latch_next = 8'h00;
			counter_upper_latch_next = 5'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fetch path

	always_comb begin
		// Space above the implemented memory decodes as no-operation
		if (pc_reg >= `PCS_IMPL_LIMIT) begin
			opcode_next = 16'h0000;
		end else begin
			opcode_next = fetch_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= `PCS_RST_PC;
			counter_high_latch_reg <= 8'h00;
			counter_upper_latch_reg <= 5'h00;
			stack_pointer_reg <= `PCS_RST_SP;
			full_reg <= 1'b0;
			underflow_reg <= 1'b0;
			overflow_reset_enable_reg <= `PCS_RST_OVR_EN;
			dev_rst_reg <= 1'b0;
			opcode_reg <= 16'h0000;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (pce) begin
			pc_reg <= pc_next;
			counter_high_latch_reg <= counter_high_latch_next;
			counter_upper_latch_reg <= counter_upper_latch_next;
			stack_pointer_reg <= stack_pointer_next;
			full_reg <= full_next;
			underflow_reg <= underflow_next;
			overflow_reset_enable_reg <= overflow_reset_enable_next;
			dev_rst_reg <= dev_rst_next;
			opcode_reg <= opcode_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign fetch_addr = pc_reg;
	assign fetch_opcode = opcode_reg;
	assign stack_full_flag = full_reg;
	assign stack_underflow_flag = underflow_reg;
	assign device_reset_out = dev_rst_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

endmodule // pcs_program_counter

//--- pcs_program_counter_monitor.sv
`timescale 1ns/10ps

module pcs_program_counter_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire pcs_pkg::pcs_op_type core_op,
	input wire logic [20:0] core_target,
	input wire logic core_int_high,
	input wire logic [15:0] fetch_rdata,
	input wire logic [20:0] fetch_addr,
	input wire logic [15:0] fetch_opcode,
	input wire logic stack_full_flag,
	input wire logic stack_underflow_flag,
	input wire logic device_reset_out
);
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	default clocking cb @(posedge pclk); endclocking
	// Frozen cycles carry no obligations
	default disable iff (!presetn || !pce);
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; !pready ##1 pready; endsequence
	property p_apb_wait; s_setup |=> s_answer; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_advance; core_op == pcs_pkg::PCS_OP_ADVANCE && !(wr_done && paddr == 32'h0)
		|=> fetch_addr == $past(fetch_addr) + 21'h2 && !fetch_addr[0]; endproperty
	property p_jump; core_op == pcs_pkg::PCS_OP_JUMP
		|=> fetch_addr == ($past(core_target) & 21'h1ffffe); endproperty
	// Overflowing push with overflow reset enabled resets the counter instead
	property p_vector; core_op == pcs_pkg::PCS_OP_INT_ACK
		|=> stack_full_flag || fetch_addr == ($past(core_int_high) ? 21'h8 : 21'h18); endproperty
	property p_fetch; presetn
		|=> fetch_opcode == ($past(fetch_addr) >= 21'h8000 ? 16'h0 : $past(fetch_rdata)); endproperty
	property p_full_sticky; stack_full_flag && !(wr_done && paddr == 32'hc)
		|=> stack_full_flag; endproperty
	property p_unf_sticky; stack_underflow_flag && !(wr_done && paddr == 32'hc)
		|=> stack_underflow_flag; endproperty
	property p_reset_pulse; device_reset_out |-> stack_full_flag ##1 !device_reset_out; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("answer not after one wait");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	a_advance: assert property (p_advance) else $error("advance not by two");
	a_jump: assert property (p_jump) else $error("jump target not loaded");
	a_vector: assert property (p_vector) else $error("wrong vector");
	a_fetch: assert property (p_fetch) else $error("wrong fetched word");
	a_full_sticky: assert property (p_full_sticky) else $error("full flag lost");
	a_unf_sticky: assert property (p_unf_sticky) else $error("underflow flag lost");
	a_reset_pulse: assert property (p_reset_pulse) else $error("bad reset pulse");
endmodule // pcs_program_counter_monitor

bind pcs_program_counter pcs_program_counter_monitor mon_u (.pclk, .presetn, .pce, .psel,
	.penable, .pwrite, .paddr, .pready, .core_op, .core_target, .core_int_high, .fetch_rdata,
	.fetch_addr, .fetch_opcode, .stack_full_flag, .stack_underflow_flag, .device_reset_out);

//--- pcs_fetch_model.sv
`timescale 1ns/10ps

module pcs_fetch_model (
	input wire logic [20:0] fetch_addr,
	output logic [15:0] fetch_rdata
);
	// Word follows its address, so a stale fetch shows
	assign fetch_rdata = ~fetch_addr[15:0];
endmodule // pcs_fetch_model

//--- program_counter_return_stack_tb.sv
`timescale 1ns/10ps

module program_counter_return_stack_tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, core_int_high = 1'h0, rst_seen = 1'h0, pce = 1'h1;
	pcs_pkg::pcs_op_type core_op = pcs_pkg::PCS_OP_NONE;
	logic [20:0] core_target = 21'h0, fetch_addr;
	logic [15:0] fetch_rdata, fetch_opcode;
	logic stack_full_flag, stack_underflow_flag, device_reset_out;
	int fail_count = 0, n_tests = 0, cyc = 0;
	always #5 pclk = ~pclk;
	pcs_program_counter dut_u (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_op(core_op), .core_target(core_target),
		.core_int_high(core_int_high), .fetch_rdata(fetch_rdata), .fetch_addr(fetch_addr),
		.fetch_opcode(fetch_opcode), .stack_full_flag(stack_full_flag),
		.stack_underflow_flag(stack_underflow_flag), .device_reset_out(device_reset_out));
	pcs_fetch_model fetch_u (.fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata));
	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (device_reset_out === 1'h1) rst_seen <= 1'h1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		// A missing answer counts against the run
		if (pready !== 1'h1) begin
			fail_count++;
			$display("mismatch pready exp 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, exp);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	task automatic op(input pcs_pkg::pcs_op_type o, input logic [20:0] t, input logic h);
		@(posedge pclk);
		core_op <= o;
		core_target <= t;
		core_int_high <= h;
		@(posedge pclk);
		core_op <= pcs_pkg::PCS_OP_NONE;
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc("sp", 32'h0c, 32'h0);
		rdc("cfg", 32'h1c, 32'h1);
		rdc("pc", 32'h20, 32'h0);
		apb(1'h0, 32'h24, 32'h0);
		chk("err", {31'h0, err}, 32'h1);
	endtask
	task automatic t_pc;
		repeat (3) op(pcs_pkg::PCS_OP_ADVANCE, 21'h0, 1'h0);
		chk("adv", {11'h0, fetch_addr}, 32'h6);
		apb(1'h1, 32'h04, 32'h12);
		apb(1'h1, 32'h08, 32'h03);
		apb(1'h1, 32'h00, 32'h35);
		chk("wlo", {11'h0, fetch_addr}, 32'h31234);
		op(pcs_pkg::PCS_OP_JUMP, 21'h101, 1'h0);
		chk("jmp", {11'h0, fetch_addr}, 32'h100);
		rdc("hl", 32'h04, 32'h12);
		rdc("lo", 32'h00, 32'h0);
		rdc("hl2", 32'h04, 32'h01);
		rdc("ul2", 32'h08, 32'h0);
	endtask
	task automatic t_stack;
		op(pcs_pkg::PCS_OP_CALL, 21'h200, 1'h0);
		// Core idle while the top entry is read
		rdc("tl", 32'h10, 32'h0);
		rdc("th", 32'h14, 32'h01);
		op(pcs_pkg::PCS_OP_INT_ACK, 21'h0, 1'h1);
		chk("vh", {11'h0, fetch_addr}, 32'h8);
		op(pcs_pkg::PCS_OP_INT_ACK, 21'h0, 1'h0);
		chk("vl", {11'h0, fetch_addr}, 32'h18);
		rdc("sp3", 32'h0c, 32'h3);
		op(pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT, 21'h0, 1'h0);
		chk("rfi", {11'h0, fetch_addr}, 32'h8);
		op(pcs_pkg::PCS_OP_RETURN_WITH_LITERAL, 21'h0, 1'h0);
		chk("rwl", {11'h0, fetch_addr}, 32'h200);
		op(pcs_pkg::PCS_OP_RETURN, 21'h0, 1'h0);
		chk("ret", {11'h0, fetch_addr}, 32'h100);
		op(pcs_pkg::PCS_OP_RETURN, 21'h0, 1'h0);
		chk("unf", {11'h0, fetch_addr}, 32'h0);
		rdc("sp0", 32'h0c, 32'h40);
		op(pcs_pkg::PCS_OP_SW_PUSH, 21'h0, 1'h0);
		rdc("sp1", 32'h0c, 32'h41);
		apb(1'h1, 32'h10, 32'h44);
		op(pcs_pkg::PCS_OP_SW_PUSH, 21'h0, 1'h0);
		op(pcs_pkg::PCS_OP_SW_POP, 21'h0, 1'h0);
		rdc("tpop", 32'h10, 32'h44);
		chk("pcp", {11'h0, fetch_addr}, 32'h0);
		apb(1'h1, 32'h0c, 32'h0);
		chk("uclr", {31'h0, stack_underflow_flag}, 32'h0);
	endtask
	task automatic t_ovf;
		apb(1'h1, 32'h1c, 32'h0);
		repeat (31) op(pcs_pkg::PCS_OP_CALL, 21'h100, 1'h0);
		rdc("sp31", 32'h0c, 32'h9f);
		op(pcs_pkg::PCS_OP_CALL, 21'h300, 1'h0);
		rdc("sp31b", 32'h0c, 32'h9f);
		rdc("t31", 32'h14, 32'h01);
		apb(1'h1, 32'h0c, 32'h0);
		rdc("spc", 32'h0c, 32'h0);
		apb(1'h1, 32'h1c, 32'h1);
		repeat (31) op(pcs_pkg::PCS_OP_CALL, 21'h100, 1'h0);
		repeat (2) op(pcs_pkg::PCS_OP_NONE, 21'h0, 1'h0);
		chk("rst", {31'h0, rst_seen}, 32'h1);
		chk("pc0", {11'h0, fetch_addr}, 32'h0);
		rdc("spf", 32'h0c, 32'h80);
		apb(1'h1, 32'h0c, 32'h9f);
		rdc("tp2", 32'h10, 32'h02);
		apb(1'h1, 32'h0c, 32'h0);
	endtask
	task automatic t_fetch;
		op(pcs_pkg::PCS_OP_JUMP, 21'h1ffffe, 1'h0);
		chk("wide", {11'h0, fetch_addr}, 32'h1ffffe);
		op(pcs_pkg::PCS_OP_NONE, 21'h0, 1'h0);
		chk("nop", {16'h0, fetch_opcode}, 32'h0);
		op(pcs_pkg::PCS_OP_JUMP, 21'h10, 1'h0);
		op(pcs_pkg::PCS_OP_NONE, 21'h0, 1'h0);
		chk("word", {16'h0, fetch_opcode}, 32'hffef);
	endtask
	task automatic t_relative_call_freeze;
		op(pcs_pkg::PCS_OP_RELATIVE_CALL, 21'h41, 1'h0);
		chk("relative_call", {11'h0, fetch_addr}, 32'h40);
		rdc("sp_rc", 32'h0c, 32'h1);
		rdc("t_rc", 32'h10, 32'h10);
		op(pcs_pkg::PCS_OP_RETURN, 21'h0, 1'h0);
		chk("rc_ret", {11'h0, fetch_addr}, 32'h10);
		// Low clock enable must swallow a whole operation
		@(posedge pclk);
		pce <= 1'h0;
		op(pcs_pkg::PCS_OP_ADVANCE, 21'h0, 1'h0);
		@(posedge pclk);
		pce <= 1'h1;
		#1;
		chk("frz", {11'h0, fetch_addr}, 32'h10);
		op(pcs_pkg::PCS_OP_ADVANCE, 21'h0, 1'h0);
		chk("thaw", {11'h0, fetch_addr}, 32'h12);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_pc;
		t_stack;
		t_ovf;
		t_fetch;
		t_relative_call_freeze;
		tally_and_finish;
	end
endmodule // program_counter_return_stack_tb
